// file: gpio_port_bank_pkg.sv
// Purpose: Constants and types for the general purpose I/O bank
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Two register groups of four eight-pin ports each
package gpio_port_bank_pkg;

  localparam int unsigned NUM_GROUPS     = 2;
  localparam int unsigned PINS_PER_GROUP = 32;
  localparam int unsigned PINS_PER_PORT  = 8;
  localparam int unsigned ADDR_W         = 12;

  // Byte offsets within one group window
  localparam logic [7:0] OFS_OUTPUT_VALUE  = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_SET    = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_CLEAR  = 8'h08;
  localparam logic [7:0] OFS_OUTPUT_TOGGLE = 8'h0C;
  localparam logic [7:0] OFS_INPUT_VALUE   = 8'h10;
  localparam logic [7:0] OFS_DIRECTION     = 8'h14;
  localparam logic [7:0] OFS_INPUT_DISABLE = 8'h18;

  // Group windows: primary and alias share one register set
  localparam logic [3:0] WIN_FIRST_GROUP        = 4'h0;
  localparam logic [3:0] WIN_SECOND_GROUP       = 4'h1;
  localparam logic [3:0] WIN_FIRST_GROUP_ALIAS  = 4'h8;
  localparam logic [3:0] WIN_SECOND_GROUP_ALIAS = 4'h9;

  localparam logic [31:0] RST_DIRECTION     = 32'h0000_0000;
  localparam logic [31:0] RST_INPUT_DISABLE = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_OUTPUT_VALUE  = 32'h0000_0000;

  typedef enum logic [2:0] {
    REG_OUT_VALUE,
    REG_OUT_SET,
    REG_OUT_CLEAR,
    REG_OUT_TOGGLE,
    REG_IN_VALUE,
    REG_DIRECTION,
    REG_IN_DISABLE,
    REG_NONE
  } reg_sel_t;

  typedef struct packed {
    logic [31:0] pin_out;
    logic [31:0] pin_oe_n;
  } pin_drive_t;

endpackage

// file: gpio_group_regs.sv
// Purpose: Register set of one 32-pin group
// Assumes: Write strobe and select from the bus decoder, same clock
// Notes:   Port A/E in lane 0 up to port D/H in lane 3
`timescale 1ns/1ns
module gpio_group_regs
  import gpio_port_bank_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire reg_sel_t    sel,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] pin_sync,
  output logic      [31:0] rdata_q,
  output logic      [31:0] dir_q,
  output logic      [31:0] out_q
);

  logic [31:0] in_dis_q;
  logic [31:0] in_value_q;
  logic [31:0] out_d;
  logic [31:0] rdata_d;

  // ************************************************************
  // Output data update
  // ************************************************************
  always_comb begin
    out_d = out_q;
    if (wr_en) begin
      unique case (sel)
        REG_OUT_VALUE:  out_d = wdata;
        REG_OUT_SET:    out_d = out_q | wdata;
        REG_OUT_CLEAR:  out_d = out_q & ~wdata;
        REG_OUT_TOGGLE: out_d = out_q ^ wdata;
        default:        out_d = out_q;
      endcase
    end
  end

  // ************************************************************
  // Read mux
  // ************************************************************
  always_comb begin
    unique case (sel)
      REG_OUT_VALUE:  rdata_d = out_q;
      REG_IN_VALUE:   rdata_d = in_value_q;
      REG_DIRECTION:  rdata_d = dir_q;
      REG_IN_DISABLE: rdata_d = in_dis_q;
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dir_q      <= RST_DIRECTION;
      in_dis_q   <= RST_INPUT_DISABLE;
      out_q      <= RST_OUTPUT_VALUE;
      in_value_q <= 32'h0000_0000;
      rdata_q    <= 32'h0000_0000;
    end else begin
      out_q      <= out_d;
      in_value_q <= pin_sync & ~in_dis_q;
      rdata_q    <= rdata_d;
      if (wr_en && sel == REG_DIRECTION) begin
        dir_q <= wdata;
      end
      if (wr_en && sel == REG_IN_DISABLE) begin
        in_dis_q <= wdata;
      end
    end
  end

endmodule

// file: gpio_port_bank.sv
// Purpose: APB general purpose I/O bank, two groups of four ports
// Assumes: Pins are asynchronous and synchronised here
// Notes:   Answers with one wait state; unmapped addresses raise pslverr
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module gpio_port_bank
  import gpio_port_bank_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [63:0]           pin_in,
  output logic      [63:0]           pin_out,
  output logic      [63:0]           pin_oe_n
);

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic reg_sel_t decode_ofs(input logic [7:0] ofs);
    reg_sel_t s;
    s = REG_NONE;
    unique case (ofs)
      OFS_OUTPUT_VALUE:  s = REG_OUT_VALUE;
      OFS_OUTPUT_SET:    s = REG_OUT_SET;
      OFS_OUTPUT_CLEAR:  s = REG_OUT_CLEAR;
      OFS_OUTPUT_TOGGLE: s = REG_OUT_TOGGLE;
      OFS_INPUT_VALUE:   s = REG_IN_VALUE;
      OFS_DIRECTION:     s = REG_DIRECTION;
      OFS_INPUT_DISABLE: s = REG_IN_DISABLE;
      default:           s = REG_NONE;
    endcase
    return s;
  endfunction

  wire logic [3:0] win       = paddr[11:8];
  wire logic       hit_first = (win == WIN_FIRST_GROUP)  || (win == WIN_FIRST_GROUP_ALIAS);
  wire logic       hit_sec   = (win == WIN_SECOND_GROUP) || (win == WIN_SECOND_GROUP_ALIAS);
  wire reg_sel_t   sel_raw   = decode_ofs(paddr[7:0]);
  wire logic       mapped    = (hit_first || hit_sec) && (sel_raw != REG_NONE);
  wire logic       setup     = psel && !penable;
  // Writes land at the access edge, where pready is sampled high
  wire logic       access    = psel && penable && pready;
  // Input register is read-only; full-word writes only
  wire logic       wr_ok     = mapped && pwrite && (pstrb == 4'hF) && (sel_raw != REG_IN_VALUE);
  wire logic       wr_first  = access && wr_ok && hit_first;
  wire logic       wr_sec    = access && wr_ok && hit_sec;

  logic            ack_q;
  logic            err_q;
  logic            grp_q;
  logic [63:0]     pin_meta_q;
  logic [63:0]     pin_sync_q;
  logic [31:0]     rd_first;
  logic [31:0]     rd_sec;
  logic [31:0]     dir_first;
  logic [31:0]     dir_sec;
  logic [31:0]     out_first;
  logic [31:0]     out_sec;
  pin_drive_t      drv_first;
  pin_drive_t      drv_sec;

  // ************************************************************
  // Pin synchroniser
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta_q <= 64'h0000_0000_0000_0000;
      pin_sync_q <= 64'h0000_0000_0000_0000;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ************************************************************
  // Register groups
  // ************************************************************
  gpio_group_regs u_first (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_en    (wr_first),
    .sel      (sel_raw),
    .wdata    (pwdata),
    .pin_sync (pin_sync_q[31:0]),
    .rdata_q  (rd_first),
    .dir_q    (dir_first),
    .out_q    (out_first)
  );

  gpio_group_regs u_sec (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_en    (wr_sec),
    .sel      (sel_raw),
    .wdata    (pwdata),
    .pin_sync (pin_sync_q[63:32]),
    .rdata_q  (rd_sec),
    .dir_q    (dir_sec),
    .out_q    (out_sec)
  );

  // ************************************************************
  // Pin drive, no pin-select involved
  // ************************************************************
  assign drv_first.pin_out  = out_first;
  assign drv_first.pin_oe_n = ~dir_first;
  assign drv_sec.pin_out    = out_sec;
  assign drv_sec.pin_oe_n   = ~dir_sec;

  // Outputs already registered inside the groups
  always_comb begin
    pin_out  = {drv_sec.pin_out,  drv_first.pin_out};
    pin_oe_n = {drv_sec.pin_oe_n, drv_first.pin_oe_n};
  end

  // ************************************************************
  // APB answer
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      grp_q <= 1'b0;
    end else begin
      ack_q <= setup;
      err_q <= setup && !(mapped && (!pwrite || wr_ok));
      grp_q <= hit_sec;
    end
  end

  always_comb begin
    pready  = ack_q;
    pslverr = ack_q && err_q;
    prdata  = (ack_q && !err_q) ? (grp_q ? rd_sec : rd_first) : 32'h0000_0000;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_set_write;
    wr_first && sel_raw == REG_OUT_SET;
  endsequence

  sequence s_refused_write;
    setup && pwrite && !wr_ok ##1 psel && penable;
  endsequence

  sequence s_read_first_out;
    setup && !pwrite && hit_first && sel_raw == REG_OUT_VALUE;
  endsequence

  property p_dir_reset;
    $fell(rst) |-> pin_oe_n == 64'hFFFF_FFFF_FFFF_FFFF;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs after reset");

  property p_oe_follows_dir;
    wr_first && sel_raw == REG_DIRECTION |=> pin_oe_n[31:0] == ~$past(pwdata);
  endproperty
  a_oe_follows_dir: assert property (p_oe_follows_dir) else $error("direction not applied");

  property p_set_only_ones;
    s_set_write |=> pin_out[31:0] == ($past(pin_out[31:0]) | $past(pwdata));
  endproperty
  a_set_only_ones: assert property (p_set_only_ones) else $error("set misbehaves");

  property p_clear_only_ones;
    wr_sec && sel_raw == REG_OUT_CLEAR
      |=> pin_out[63:32] == ($past(pin_out[63:32]) & ~$past(pwdata));
  endproperty
  a_clear_only_ones: assert property (p_clear_only_ones) else $error("clear misbehaves");

  property p_toggle;
    wr_first && sel_raw == REG_OUT_TOGGLE
      |=> pin_out[31:0] == ($past(pin_out[31:0]) ^ $past(pwdata));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle misbehaves");

  property p_wo_reads_zero;
    setup && !pwrite && mapped && (sel_raw inside {REG_OUT_SET, REG_OUT_CLEAR, REG_OUT_TOGGLE})
      |=> pready && prdata == 32'h0000_0000;
  endproperty
  a_wo_reads_zero: assert property (p_wo_reads_zero) else $error("write-only read nonzero");

  property p_pready_one_wait;
    setup |=> pready;
  endproperty
  a_pready_one_wait: assert property (p_pready_one_wait) else $error("late pready");

  property p_alias_write;
    wr_sec && win == WIN_SECOND_GROUP_ALIAS && sel_raw == REG_OUT_VALUE
      |=> pin_out[63:32] == $past(pwdata);
  endproperty
  a_alias_write: assert property (p_alias_write) else $error("alias write lost");

  property p_disabled_reads_zero;
    setup && !pwrite && hit_first && sel_raw == REG_IN_VALUE && u_first.in_dis_q[0]
      ##1 u_first.in_dis_q[0] |-> prdata[0] == 1'b0;
  endproperty
  a_disabled_reads_zero: assert property (p_disabled_reads_zero) else $error("disabled pin read");

  // ************************************************************
  // Further checks: register state, refusals, bus timing
  // ************************************************************
  property p_idis_reset;
    $fell(rst) |-> u_first.in_dis_q == RST_INPUT_DISABLE && u_sec.in_dis_q == RST_INPUT_DISABLE;
  endproperty
  a_idis_reset: assert property (p_idis_reset) else $error("input path enabled after reset");

  property p_idis_write;
    wr_first && sel_raw == REG_IN_DISABLE |=> u_first.in_dis_q == $past(pwdata);
  endproperty
  a_idis_write: assert property (p_idis_write) else $error("input disable not applied");

  property p_in_value_first;
    1'b1 |=> u_first.in_value_q == ($past(pin_sync_q[31:0]) & ~$past(u_first.in_dis_q));
  endproperty
  a_in_value_first: assert property (p_in_value_first) else $error("first input sample wrong");

  property p_in_value_sec;
    1'b1 |=> u_sec.in_value_q == ($past(pin_sync_q[63:32]) & ~$past(u_sec.in_dis_q));
  endproperty
  a_in_value_sec: assert property (p_in_value_sec) else $error("second input sample wrong");

  property p_read_out;
    s_read_first_out |=> pready && prdata == pin_out[31:0];
  endproperty
  a_read_out: assert property (p_read_out) else $error("output readback wrong");

  property p_read_dir;
    setup && !pwrite && hit_sec && sel_raw == REG_DIRECTION |=> prdata == ~pin_oe_n[63:32];
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("direction readback wrong");

  property p_alias_read;
    setup && !pwrite && win == WIN_FIRST_GROUP_ALIAS && sel_raw == REG_OUT_VALUE
      |=> prdata == pin_out[31:0];
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("alias read wrong");

  property p_unmapped_err;
    setup && !mapped |=> pready && pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access accepted");

  property p_ro_err;
    setup && pwrite && mapped && sel_raw == REG_IN_VALUE |=> pslverr;
  endproperty
  a_ro_err: assert property (p_ro_err) else $error("input register write accepted");

  property p_strobe_err;
    setup && pwrite && pstrb != 4'hF |=> pslverr;
  endproperty
  a_strobe_err: assert property (p_strobe_err) else $error("partial write accepted");

  property p_refused_keep;
    s_refused_write |=> $stable(pin_out) && $stable(pin_oe_n);
  endproperty
  a_refused_keep: assert property (p_refused_keep) else $error("refused write changed pins");

  property p_idle_quiet;
    !psel |=> !pready && prdata == 32'h0000_0000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request");

  property p_pready_single;
    pready |=> !pready;
  endproperty
  a_pready_single: assert property (p_pready_single) else $error("pready held too long");

  property p_set_sec;
    wr_sec && sel_raw == REG_OUT_SET
      |=> pin_out[63:32] == ($past(pin_out[63:32]) | $past(pwdata));
  endproperty
  a_set_sec: assert property (p_set_sec) else $error("second group set wrong");

  property p_clear_first;
    wr_first && sel_raw == REG_OUT_CLEAR
      |=> pin_out[31:0] == ($past(pin_out[31:0]) & ~$past(pwdata));
  endproperty
  a_clear_first: assert property (p_clear_first) else $error("first group clear wrong");

  property p_toggle_sec;
    wr_sec && sel_raw == REG_OUT_TOGGLE
      |=> pin_out[63:32] == ($past(pin_out[63:32]) ^ $past(pwdata));
  endproperty
  a_toggle_sec: assert property (p_toggle_sec) else $error("second group toggle wrong");

  property p_out_hold;
    !wr_first && !wr_sec |=> $stable(pin_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("pins changed without write");

  property p_dir_hold;
    !(wr_first && sel_raw == REG_DIRECTION) |=> pin_oe_n[31:0] == $past(pin_oe_n[31:0]);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed without write");

endmodule

// file: gpio_board_model.sv
// Purpose: Board pins of the I/O bank, buttons and LEDs
// Assumes: Pull-up on every pin, a pressed button pulls to 0
// Notes:   A driven pin reads back its own output level
`timescale 1ns/1ns
module gpio_board_model (
  input  wire logic [63:0] pin_out,
  input  wire logic [63:0] pin_oe_n,
  input  wire logic [63:0] btn_press,
  output logic      [63:0] pin_in
);
  // Driver wins over button; released pin floats high
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ~btn_press);
endmodule

// file: gpio_port_bank_bench.sv
// Purpose: Self-checking bench of the I/O bank over APB
// Assumes: One wait state answers, board model on the pins
// Notes:   Inputs need three edges through the synchronisers
`timescale 1ns/1ns
module gpio_port_bank_bench;
  import gpio_port_bank_pkg::*;
  localparam logic [63:0] BTN = 64'h0F0F_3C3C_1234_5678;
  logic              clk_sys = 1'b0;
  logic              rst     = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  logic [3:0]        pstrb   = 4'hF;
  logic [63:0]       btn_press = '0;
  logic [31:0]       prdata, rd, exp;
  logic              pready, pslverr, err;
  logic [63:0]       pin_in, pin_out, pin_oe_n;
  logic [3:0]        win [2] = '{WIN_FIRST_GROUP, WIN_SECOND_GROUP};
  logic [7:0]        ofs [3] = '{OFS_OUTPUT_SET, OFS_OUTPUT_CLEAR, OFS_OUTPUT_TOGGLE};
  logic [31:0]       msk [3] = '{32'h0000_00FF, 32'hF000_000F, 32'h0FF0_0FF0};
  int                bad_count = 0;
  int                tests_run = 0;

  always #5 clk_sys = ~clk_sys;

  gpio_port_bank uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  gpio_board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .btn_press(btn_press),
    .pin_in(pin_in));

  // **********************************************
  // Tasks
  // **********************************************
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
    int   n;
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 16 && !done; n++) begin
      @(posedge clk_sys);
      done = (pready === 1'b1);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      bad_count++;
      $display("ERROR pready expected 1 seen 0");
      give_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hF);
    chk("wr_err", 64'h0, 64'(err));
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000, 4'hF);
    chk(nm, 64'(e), 64'(rd));
    chk("rd_err", 64'h0, 64'(err));
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end

  // **********************************************
  // Scenarios
  // **********************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("oe_n_rst", {64{1'b1}}, pin_oe_n);
    chk("out_rst", 64'h0, pin_out);
    for (int g = 0; g < 2; g++) begin
      rdc("dir_rst", {win[g], OFS_DIRECTION}, RST_DIRECTION);
      rdc("idis_rst", {win[g], OFS_INPUT_DISABLE}, RST_INPUT_DISABLE);
      rdc("out_rst", {win[g], OFS_OUTPUT_VALUE}, RST_OUTPUT_VALUE);
      rdc("in_dis", {win[g], OFS_INPUT_VALUE}, 32'h0000_0000);
    end
    btn_press <= BTN;
    for (int g = 0; g < 2; g++)
      wr({win[g], OFS_INPUT_DISABLE}, 32'h0000_0000);
    repeat (4) @(posedge clk_sys);
    rdc("in_a", {WIN_FIRST_GROUP, OFS_INPUT_VALUE}, ~BTN[31:0]);
    rdc("in_b", {WIN_SECOND_GROUP, OFS_INPUT_VALUE}, ~BTN[63:32]);
    wr({WIN_FIRST_GROUP, OFS_INPUT_DISABLE}, 32'hFF00_0000);
    repeat (4) @(posedge clk_sys);
    rdc("in_part", {WIN_FIRST_GROUP, OFS_INPUT_VALUE}, ~BTN[31:0] & 32'h00FF_FFFF);
    wr({WIN_FIRST_GROUP, OFS_DIRECTION}, 32'hFFFF_FFFF);
    wr({WIN_FIRST_GROUP, OFS_OUTPUT_VALUE}, 32'hA5C3_1E78);
    @(negedge clk_sys);
    chk("oe_n_a", {32'hFFFF_FFFF, 32'h0000_0000}, pin_oe_n);
    chk("out_a", {32'h0, 32'hA5C3_1E78}, pin_out);
    rdc("out_alias", {WIN_FIRST_GROUP_ALIAS, OFS_OUTPUT_VALUE}, 32'hA5C3_1E78);
    repeat (4) @(posedge clk_sys);
    rdc("in_loop", {WIN_FIRST_GROUP, OFS_INPUT_VALUE}, 32'h00C3_1E78);
    exp = 32'hA5C3_1E78;
    for (int i = 0; i < 3; i++) begin
      wr({WIN_FIRST_GROUP_ALIAS, ofs[i]}, msk[i]);
      exp = (i == 0) ? (exp | msk[i]) : (i == 1) ? (exp & ~msk[i]) : (exp ^ msk[i]);
      rdc("out_mod", {WIN_FIRST_GROUP, OFS_OUTPUT_VALUE}, exp);
      rdc("wo_read", {WIN_FIRST_GROUP, ofs[i]}, 32'h0000_0000);
    end
    wr({WIN_SECOND_GROUP_ALIAS, OFS_DIRECTION}, 32'h0000_FF00);
    wr({WIN_SECOND_GROUP_ALIAS, OFS_OUTPUT_VALUE}, 32'h1122_3344);
    @(negedge clk_sys);
    chk("oe_n_b", {32'hFFFF_00FF, 32'h0000_0000}, pin_oe_n);
    chk("out_b", {32'h1122_3344, exp}, pin_out);
    xfer({WIN_FIRST_GROUP, 8'h1C}, 1'b0, 32'h0000_0000, 4'hF);
    chk("unmapped_err", 64'h1, 64'(err));
    xfer({WIN_FIRST_GROUP, OFS_INPUT_VALUE}, 1'b1, 32'hFFFF_FFFF, 4'hF);
    chk("ro_err", 64'h1, 64'(err));
    xfer({WIN_FIRST_GROUP, OFS_OUTPUT_VALUE}, 1'b1, 32'h0000_0000, 4'h3);
    chk("strb_err", 64'h1, 64'(err));
    rdc("out_kept", {WIN_FIRST_GROUP, OFS_OUTPUT_VALUE}, exp);
    give_verdict();
  end
endmodule
